/* core/lss_pkg.sv */
// ==========================================================
// Line-state status bank constants
package lss_pkg;

  // ==========================================================
  // Register byte offsets on the bus
  localparam logic [7:0] LSS_STATUS_OFS = 8'h10;
  localparam logic [7:0] LSS_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] LSS_IRQ_MASK_OFS = 8'h18;

  // ==========================================================
  // Field positions of the line-state status word
  localparam int LSS_REV_LSB = 11;
  localparam int LSS_REV_W = 5;
  localparam int LSS_SIGLOST_BIT = 10;
  localparam int LSS_PRIOR_LSB = 8;
  localparam int LSS_CUR_LSB = 5;

  // Arbitrary neutral revision code
  localparam logic [4:0] LSS_REV_DEFAULT = 5'h15;

  // ==========================================================
  // Interrupt bit layout, shared by status and mask
  localparam int LSS_IRQ_W = 2;
  localparam int LSS_IRQ_CHG_BIT = 0;
  localparam int LSS_IRQ_SIG_BIT = 1;
  localparam logic [1:0] LSS_IRQ_STAT_RST = 2'h0;
  localparam logic [1:0] LSS_IRQ_MASK_RST = 2'h0;

  // ==========================================================
  // Like-pair counter thresholds
  localparam logic [2:0] LSS_PAIR_FULL = 3'h7;
  localparam logic [2:0] LSS_PAIR_IDLE4 = 3'h1;

  typedef enum logic [2:0] {
    LSS_NLS   = 3'h0,
    LSS_ALS   = 3'h1,
    LSS_UNDEF = 3'h2,
    LSS_ILS4  = 3'h3,
    LSS_QLS   = 3'h4,
    LSS_MLS   = 3'h5,
    LSS_HLS   = 3'h6,
    LSS_ILS16 = 3'h7
  } lss_line_type;

  typedef enum logic [1:0] {
    LSS_P_QLS   = 2'h0,
    LSS_P_MLS   = 2'h1,
    LSS_P_HLS   = 2'h2,
    LSS_P_ILS16 = 2'h3
  } lss_prior_type;

  localparam lss_line_type LSS_CUR_RST = LSS_NLS;
  localparam lss_prior_type LSS_PRIOR_RST = LSS_P_QLS;

  // True for the states whose exit is recorded
  function automatic logic lss_is_recorded(input lss_line_type s);
    return (s == LSS_QLS) || (s == LSS_MLS) || (s == LSS_HLS) || (s == LSS_ILS16);
  endfunction

  function automatic lss_prior_type lss_to_prior(input lss_line_type s);
    lss_prior_type p;
    p = LSS_P_QLS;
    case (s)
      LSS_MLS: p = LSS_P_MLS;
      LSS_HLS: p = LSS_P_HLS;
      LSS_ILS16: p = LSS_P_ILS16;
      default: p = LSS_P_QLS;
    endcase
    return p;
  endfunction

endpackage

/* core/lss_cond_if.sv */
`timescale 1ns/1ps
// ==========================================================
// Recognized line condition from tracker to register bank
interface lss_cond_if;
  import lss_pkg::*;
  lss_line_type current;
  lss_prior_type prior;
  logic changed;
  modport src(output current, output prior, output changed);
  modport dst(input current, input prior, input changed);
endinterface

/* core/lss_cond_track.sv */
`timescale 1ns/1ps
// ==========================================================
// Latches reported line conditions and the prior condition
module lss_cond_track
  import lss_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] candidate_cond_i,
  input wire logic [2:0] like_pair_count_i,
  lss_cond_if.src cond
);

  lss_line_type cur_r, cur_nxt;
  lss_prior_type prior_r, prior_nxt;
  logic chg_r, chg_nxt;
  logic report;
  lss_line_type cand;

  always_comb begin
    cand = lss_line_type'(candidate_cond_i);
    // Idle-4 needs only two pairs, everything else eight
    report = (like_pair_count_i == LSS_PAIR_FULL) ||
             (cand == LSS_ILS4 && like_pair_count_i == LSS_PAIR_IDLE4);
    cur_nxt = cur_r;
    prior_nxt = prior_r;
    chg_nxt = 1'b0;
    // The undefined code is never latched, so the field cannot show it
    if (report && cand != LSS_UNDEF && cand != cur_r) begin
      cur_nxt = cand;
      chg_nxt = 1'b1;
      if (lss_is_recorded(cur_r)) begin
        prior_nxt = lss_to_prior(cur_r);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r <= LSS_CUR_RST;
      prior_r <= LSS_PRIOR_RST;
      chg_r <= 1'b0;
    end else if (ce_i) begin
      cur_r <= cur_nxt;
      prior_r <= prior_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign cond.current = cur_r;
  assign cond.prior = prior_r;
  assign cond.changed = chg_r;

endmodule

/* core/lss_status_bank.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// What this block does
// - Read-only 16-bit line-state status register at 0x10; writes ignored.
// - Bits 15..11 return a fixed per-variant five-bit revision code.
// - Bit 10 is the inverse of the optical presence input, registered one cycle late.
// - Prior field loads only when leaving quiet, master, halt or idle-16.
// - Prior codes: quiet 00, master 01, halt 10, idle-16 11.
// - Bits 7..5 hold latest condition; noise 000, active 001, 010 unused.
// - Codes 011 idle-4, 100 quiet, 101 master, 110 halt, 111 idle-16.
// - Report after pair count seven; idle-4 after two idle pairs.
module lss_status_bank
  import lss_pkg::*;
#(
  parameter logic [4:0] SILICON_REV = LSS_REV_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic optical_presence_i,
  input wire logic [2:0] candidate_cond_i,
  input wire logic [2:0] like_pair_count_i
);

  // ==========================================================
  // Line condition tracker
  lss_cond_if cond();

  lss_cond_track u_lss_cond_track (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .candidate_cond_i(candidate_cond_i),
    .like_pair_count_i(like_pair_count_i),
    .cond(cond)
  );

  // ==========================================================
  // Bus and interrupt state
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic irq_r, irq_nxt;
  logic pres_r, pres_nxt;
  logic [LSS_IRQ_W-1:0] istat_r, istat_nxt;
  logic [LSS_IRQ_W-1:0] imask_r, imask_nxt;
  logic [15:0] status_word;
  logic [LSS_IRQ_W-1:0] events;
  logic req;
  logic wr_stat;
  logic wr_mask;

  always_comb begin
    status_word = 16'h0000;
    status_word[LSS_REV_LSB +: LSS_REV_W] = SILICON_REV;
    status_word[LSS_SIGLOST_BIT] = ~pres_r;
    status_word[LSS_PRIOR_LSB +: 2] = cond.prior;
    status_word[LSS_CUR_LSB +: 3] = cond.current;
  end

  always_comb begin
    // One request per ack; the gap cycle drops ack again
    req = wb_cyc_i && wb_stb_i && !ack_r;
    wr_stat = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == LSS_IRQ_STAT_OFS);
    wr_mask = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == LSS_IRQ_MASK_OFS);
    events = '0;
    events[LSS_IRQ_CHG_BIT] = cond.changed;
    events[LSS_IRQ_SIG_BIT] = (optical_presence_i != pres_r);
    ack_nxt = req;
    pres_nxt = optical_presence_i;
    dat_nxt = dat_r;
    if (req && !wb_we_i) begin
      // Reads are side-effect free and show live fields
      if (wb_adr_i == LSS_STATUS_OFS) begin
        dat_nxt = {16'h0000, status_word};
      end else if (wb_adr_i == LSS_IRQ_STAT_OFS) begin
        dat_nxt = {{(32-LSS_IRQ_W){1'b0}}, istat_r};
      end else if (wb_adr_i == LSS_IRQ_MASK_OFS) begin
        dat_nxt = {{(32-LSS_IRQ_W){1'b0}}, imask_r};
      end else begin
        dat_nxt = 32'h00000000;
      end
    end
    // Writes to the status word fall through: nothing decodes them
    istat_nxt = istat_r;
    if (wr_stat) begin
      istat_nxt = istat_r & ~wb_dat_i[LSS_IRQ_W-1:0];
    end
    // A new event wins over a simultaneous clear
    istat_nxt = istat_nxt | events;
    imask_nxt = imask_r;
    if (wr_mask) begin
      imask_nxt = wb_dat_i[LSS_IRQ_W-1:0];
    end
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      irq_r <= 1'b0;
      pres_r <= 1'b1;
      istat_r <= LSS_IRQ_STAT_RST;
      imask_r <= LSS_IRQ_MASK_RST;
    end else if (ce_i) begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      irq_r <= irq_nxt;
      pres_r <= pres_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;

endmodule

/* testbench/lss_status_bank_assertions.sv */
`timescale 1ns/1ps
// ========
// Bus-side checks of the status bank
module lss_status_bank_assertions
  import lss_pkg::*;
#(
  parameter logic [4:0] SILICON_REV = LSS_REV_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  wire rd = wb_ack_o & !wb_we_i;
  wire rd10 = rd & (wb_adr_i == LSS_STATUS_OFS);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A frozen clock enable may hold ack for longer than one cycle
  property p_once; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  a_once: assert property (p_once) else $error("ack held");
  property p_lat; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
  a_lat: assert property (p_lat) else $error("ack late");
  property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_cause: assert property (p_cause) else $error("stray ack");
  property p_rev; rd10 |-> wb_dat_o[15:11] == SILICON_REV; endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_pad; rd10 |-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[4:0] == 5'h0; endproperty
  a_pad: assert property (p_pad) else $error("bad padding");
  property p_unmap; rd && wb_adr_i[7:5] != 3'h0 |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_undef; rd10 |-> wb_dat_o[7:5] != 3'h2; endproperty
  a_undef: assert property (p_undef) else $error("undefined code");
  // Read data may only move in the answer cycle of a read
  property p_hold; $changed(wb_dat_o) && !$past(rst_i) |-> rd; endproperty
  a_hold: assert property (p_hold) else $error("data moved");
endmodule
bind lss_status_bank lss_status_bank_assertions #(.SILICON_REV(SILICON_REV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

/* testbench/line_state_status_register_test.sv */
`timescale 1ns/1ps
// ========
// Status bank bench
module line_state_status_register_test;
  import lss_pkg::*;
  localparam logic [4:0] REV = 5'h0A; // Arbitrary code
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, pres = 1'h1, ce = 1'h1, ack, irq;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, q;
  logic [2:0] cand = 3'h0, cnt = 3'h0;
  logic [1:0] p = 2'h0;
  int err_total = 0, comparisons = 0, cycles = 0;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("MISMATCH %0t %h %h", $time, a, b); end end
  always #5 clk_i = ~clk_i;
  lss_status_bank #(.SILICON_REV(REV)) u_lss_status_bank (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .irq_o(irq), .optical_presence_i(pres), .candidate_cond_i(cand), .like_pair_count_i(cnt));
  task automatic results;
    $display("Mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // No latency is assumed: the request stands until ack is sampled
  // Only the bench timeout ends a wait that never sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'hF, d};
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rd;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rep(input logic [2:0] c, input logic [2:0] n);
    @(posedge clk_i);
    {cand, cnt} <= {c, n};
    @(posedge clk_i);
    {cand, cnt} <= 6'h0;
  endtask
  function automatic logic [31:0] sw(input logic [2:0] c);
    return {16'h0, REV, !pres, p, c, 5'h0};
  endfunction
  task automatic t_reads;
    wb(1'h0, LSS_STATUS_OFS, 32'h0);
    `CHK(q, sw(3'h0))
    wb(1'h1, LSS_STATUS_OFS, 32'hFFFF);
    wb(1'h0, LSS_STATUS_OFS, 32'h0);
    `CHK(q, sw(3'h0))
    wb(1'h0, 8'h20, 32'h0);
    `CHK(q, 32'h0)
  endtask
  task automatic t_signal;
    @(posedge clk_i);
    pres <= 1'h0;
    wb(1'h0, LSS_STATUS_OFS, 32'h0);
    `CHK(q, sw(3'h0))
    wb(1'h1, LSS_IRQ_MASK_OFS, 32'h2);
    `CHK(irq, 1'h1)
    wb(1'h1, LSS_IRQ_STAT_OFS, 32'h2);
    wb(1'h0, LSS_IRQ_STAT_OFS, 32'h0);
    `CHK({q, irq}, 33'h0)
  endtask
  task automatic t_states;
    for (int i = 3; i < 8; i++) begin
      rep(3'(i), (i == 3) ? 3'h1 : 3'h7);
      wb(1'h0, LSS_STATUS_OFS, 32'h0);
      `CHK(q, sw(3'(i)))
      rep(3'h1, 3'h7);
      if (i > 3) p = 2'(i - 4);
      wb(1'h0, LSS_STATUS_OFS, 32'h0);
      `CHK(q, sw(3'h1))
    end
    rep(3'h2, 3'h7);
    rep(3'h6, 3'h6);
    wb(1'h0, LSS_STATUS_OFS, 32'h0);
    `CHK(q, sw(3'h1))
  endtask
  // A report offered while the clock enable is low must leave every field as it was
  task automatic t_freeze;
    @(posedge clk_i);
    ce <= 1'h0;
    rep(3'h4, 3'h7);
    @(posedge clk_i);
    ce <= 1'h1;
    wb(1'h0, LSS_STATUS_OFS, 32'h0);
    `CHK(q, sw(3'h1))
  endtask
  task automatic t_irq;
    wb(1'h1, LSS_IRQ_STAT_OFS, 32'h3);
    wb(1'h1, LSS_IRQ_MASK_OFS, 32'h1);
    `CHK(irq, 1'h0)
    rep(3'h5, 3'h7);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'h1)
    wb(1'h1, LSS_IRQ_MASK_OFS, 32'h0);
    `CHK(irq, 1'h0)
  endtask
  // Mid-run reset with presence restored, so no presence event follows release
  task automatic t_reset;
    wb(1'h1, LSS_IRQ_MASK_OFS, 32'h3);
    @(posedge clk_i);
    {rst_i, pres} <= 2'h3;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    p = 2'h0;
    wb(1'h0, LSS_IRQ_STAT_OFS, 32'h0);
    `CHK({q, irq}, 33'h0)
    wb(1'h0, LSS_IRQ_MASK_OFS, 32'h0);
    `CHK(q, 32'h0)
    wb(1'h0, LSS_STATUS_OFS, 32'h0);
    `CHK(q, sw(3'h0))
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reads();
    t_signal();
    t_states();
    t_freeze();
    t_irq();
    t_reset();
    results();
  end
  always @(posedge clk_i) begin
    if (++cycles > 2000) begin
      err_total++;
      results();
    end
  end
endmodule
